// >>> hp_consts.svh
// constants for the secure coprocessor host port
`ifndef HP_CONSTS_SVH
`define HP_CONSTS_SVH
`define HP_DEV_ADDR 8'hc0
`define HP_DEV_ADDR_HI 6'h30
`define HP_DEV_HI 7
`define HP_DEV_LO 2
`define HP_SEL_BIT 1
`define HP_RW_BIT 0
`define HP_ST_RDY_BIT 0
`define HP_ST_BUSY_BIT 1
`define HP_ST_CHAL_BIT 2
`define HP_ST_RSVD_HI 4
`define HP_ST_RSVD_LO 3
`define HP_ST_RSVD 2'h0
`define HP_ERR_OK 3'h0
`define HP_ERR_LOCKOUT 3'h1
`define HP_ERR_MALFORMED 3'h2
`define HP_ERR_PENALTY 3'h3
`define HP_ERR_AUTH 3'h4
`define HP_BUF_DEPTH 64
`define HP_BUF_AW 6
`define HP_NVM_BYTES 512
`define HP_NVM_AW 9
`define HP_SERIAL_BASE 9'h020
`define HP_LOCK_ADDR 9'h02f
`define HP_LOCK_SHIPPED 8'h02
`define HP_LOCK_ALL 8'hff
`define HP_LOCK_CLOSED 2'h3
`define HP_LOCK_CONF 2'h2
`define HP_LOCK_OPEN 2'h0
`define HP_NK_PLAIN_RD 3'h0
`define HP_NK_PLAIN_WR 3'h1
`define HP_NK_CIPH_WR 3'h2
`define HP_NK_HASH_RD 3'h3
`define HP_NK_SERIAL_RD 3'h4
`define HP_IDLE_BYTE 8'hff
`define HP_BYTE_OPCODE 8'h00
`define HP_BYTE_SIZE 8'h01
`define HP_BYTE_DATA0 8'h02
`define HP_BITS_PER_BYTE 4'h8
`define HP_BIT_LAST 4'h7
`define HP_CLK_MHZ 100
`define HP_PENALTY_TIME_US 1000
`define HP_PENALTY_CYCLES (`HP_PENALTY_TIME_US * `HP_CLK_MHZ)
`endif

// >>> hp_pkg.sv
// types shared by the host port modules
package hp_pkg;
  typedef enum logic [3:0]
  {
    FR_NONE = 4'h1,
    FR_STATUS = 4'h2,
    FR_RESULT = 4'h4,
    FR_CMD = 4'h8
  } hp_frame_t;

  typedef enum logic [4:0]
  {
    LK_IDLE = 5'h01,
    LK_RX = 5'h02,
    LK_ACK_OUT = 5'h04,
    LK_TX = 5'h08,
    LK_ACK_IN = 5'h10
  } hp_link_st_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    hp_link_st_t st;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic first;
    logic rw;
    logic send;
    logic drv;
    logic oe_n;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_first;
    logic tx_req;
    logic frame_end;
  } hp_link_t;

  typedef struct packed {
    hp_frame_t frame;
    logic [7:0] idx;
    logic ack_ok;
    logic [7:0] tx_data;
    logic [7:0] cmd_code;
    logic [7:0] cmd_size;
    logic cmd_start;
    logic exec;
    logic [7:0] res_len;
    logic [2:0] err;
    logic chal;
    logic pen_act;
    logic [31:0] pen_cnt;
    logic [7:0] stat;
    logic [7:0] lock;
    logic [7:0] eng_rdata;
    logic [7:0] nvm_rdata;
    logic nvm_done;
    logic nvm_refused;
  } hp_core_t;
endpackage : hp_pkg

// >>> hp_twi_link.sv
// two-wire slave bit engine: framing, byte shifting and acknowledge
`timescale 1ns/10ps
`include "hp_consts.svh"
module hp_twi_link
  import hp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic ack_ok,
  input wire logic [7:0] tx_data,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_first,
  output logic tx_req,
  output logic frame_end
);
  hp_link_t q;
  hp_link_t d;
  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;

  always_comb
  begin
    d = q;
    d.rx_valid = 1'b0;
    d.tx_req = 1'b0;
    d.frame_end = 1'b0;
    d.drv = 1'b0;
    d.scl_s1 = scl_in;
    d.scl_s2 = q.scl_s1;
    d.scl_d = q.scl_s2;
    d.sda_s1 = sda_in;
    d.sda_s2 = q.sda_s1;
    d.sda_d = q.sda_s2;
    rise = q.scl_s2 & ~q.scl_d;
    fall = ~q.scl_s2 & q.scl_d;
    start_c = q.scl_s2 & q.scl_d & q.sda_d & ~q.sda_s2;
    stop_c = q.scl_s2 & q.scl_d & ~q.sda_d & q.sda_s2;
    if (start_c)
    begin
      d.st = LK_RX;
      d.cnt = 4'h0;
      d.first = 1'b1;
      d.oe_n = 1'b1;
    end
    else if (stop_c)
    begin
      d.st = LK_IDLE;
      d.oe_n = 1'b1;
      d.frame_end = 1'b1;
    end
    else
    begin
      unique case (q.st)
        LK_IDLE:
        begin
          d.oe_n = 1'b1;
        end
        LK_RX:
        begin
          if (rise && q.cnt != `HP_BITS_PER_BYTE)
          begin
            d.shreg = {q.shreg[6:0], q.sda_s2};
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == `HP_BIT_LAST)
            begin
              d.rx_valid = 1'b1;
              d.rx_data = {q.shreg[6:0], q.sda_s2};
              d.rx_first = q.first;
              if (q.first)
              begin
                d.rw = q.sda_s2;
              end
            end
          end
          else if (fall && q.cnt == `HP_BITS_PER_BYTE)
          begin
            // refused bytes are left unanswered and the rest of the frame ignored
            if (ack_ok)
            begin
              d.oe_n = 1'b0;
              d.st = LK_ACK_OUT;
            end
            else
            begin
              d.st = LK_IDLE;
            end
          end
        end
        LK_ACK_OUT:
        begin
          if (rise && q.rw)
          begin
            d.tx_req = 1'b1;
          end
          else if (fall)
          begin
            d.first = 1'b0;
            d.cnt = 4'h0;
            if (q.rw)
            begin
              d.shreg = tx_data;
              d.oe_n = tx_data[7];
              d.st = LK_TX;
            end
            else
            begin
              d.oe_n = 1'b1;
              d.st = LK_RX;
            end
          end
        end
        LK_TX:
        begin
          if (fall)
          begin
            if (q.cnt == `HP_BIT_LAST)
            begin
              d.oe_n = 1'b1;
              d.st = LK_ACK_IN;
            end
            else
            begin
              d.cnt = q.cnt + 4'h1;
              d.shreg = {q.shreg[6:0], 1'b0};
              d.oe_n = q.shreg[6];
            end
          end
        end
        LK_ACK_IN:
        begin
          if (rise)
          begin
            d.send = ~q.sda_s2;
            d.tx_req = ~q.sda_s2;
          end
          else if (fall)
          begin
            if (q.send)
            begin
              d.shreg = tx_data;
              d.oe_n = tx_data[7];
              d.cnt = 4'h0;
              d.st = LK_TX;
            end
            else
            begin
              d.st = LK_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '{st: LK_IDLE, oe_n: 1'b1, scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
             sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1, default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  assign sda_out = q.drv;
  assign sda_oe_n = q.oe_n;
  assign rx_valid = q.rx_valid;
  assign rx_data = q.rx_data;
  assign rx_first = q.rx_first;
  assign tx_req = q.tx_req;
  assign frame_end = q.frame_end;
endmodule : hp_twi_link

// >>> hp_host_port.sv
// host port of the secure coprocessor: result buffer, status and lock logic
`timescale 1ns/10ps
`include "hp_consts.svh"
module hp_host_port
  import hp_pkg::*;
#(
  parameter int PENALTY_CYCLES = `HP_PENALTY_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic cmd_start,
  output logic [7:0] cmd_code,
  output logic [7:0] cmd_size,
  input wire logic eng_done,
  input wire logic [7:0] eng_result_len,
  input wire logic [2:0] eng_error,
  input wire logic eng_penalty,
  input wire logic eng_challenge_ok,
  input wire logic eng_buf_we,
  input wire logic [5:0] eng_buf_addr,
  input wire logic [7:0] eng_buf_wdata,
  output logic [7:0] eng_buf_rdata,
  input wire logic nvm_req,
  input wire logic [2:0] nvm_kind,
  input wire logic [8:0] nvm_addr,
  input wire logic [7:0] nvm_wdata,
  input wire logic lock_cmd,
  output logic [7:0] nvm_rdata,
  output logic nvm_done,
  output logic nvm_refused,
  output logic [7:0] lock_value,
  output logic [7:0] host_port_condition
);
  hp_core_t q;
  hp_core_t d;
  logic [7:0] buf_mem [`HP_BUF_DEPTH];
  logic [7:0] nvm_mem [`HP_NVM_BYTES];
  logic lk_rx_valid;
  logic [7:0] lk_rx_data;
  logic lk_rx_first;
  logic lk_tx_req;
  logic lk_frame_end;
  logic busy_now;
  logic host_we;
  logic [`HP_BUF_AW-1:0] host_waddr;
  logic nvm_we;

  function automatic logic [7:0] hp_status(input logic [2:0] err, input logic chal,
                                          input logic busy, input logic [7:0] len);
    hp_status = {err, `HP_ST_RSVD, chal, busy, len != 8'h00};
  endfunction : hp_status

  function automatic logic hp_busy(input logic exec, input logic pen, input logic [2:0] err);
    hp_busy = exec | pen | (err == `HP_ERR_LOCKOUT);
  endfunction : hp_busy

  function automatic logic hp_nvm_allowed(input logic [1:0] fld, input logic [2:0] kind,
                                          input logic [8:0] addr);
    logic conf;
    conf = (fld == `HP_LOCK_CONF);
    hp_nvm_allowed = 1'b0;
    if (kind == `HP_NK_SERIAL_RD)
    begin
      hp_nvm_allowed = (addr >= `HP_SERIAL_BASE) && (addr <= `HP_LOCK_ADDR);
    end
    else if (addr == `HP_LOCK_ADDR && kind != `HP_NK_PLAIN_RD && kind != `HP_NK_HASH_RD)
    begin
      // lock byte changes only through the lock command or a reset, which reloads the shipped value
      hp_nvm_allowed = 1'b0;
    end
    else
    begin
      unique case (kind)
        `HP_NK_PLAIN_RD: hp_nvm_allowed = ~conf;
        `HP_NK_PLAIN_WR: hp_nvm_allowed = 1'b1;
        `HP_NK_CIPH_WR: hp_nvm_allowed = conf;
        `HP_NK_HASH_RD: hp_nvm_allowed = conf;
        default: hp_nvm_allowed = 1'b0;
      endcase
    end
  endfunction : hp_nvm_allowed

  hp_twi_link u_link (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .ack_ok(q.ack_ok),
    .tx_data(q.tx_data),
    .rx_valid(lk_rx_valid),
    .rx_data(lk_rx_data),
    .rx_first(lk_rx_first),
    .tx_req(lk_tx_req),
    .frame_end(lk_frame_end)
  );

  assign busy_now = hp_busy(q.exec, q.pen_act, q.err);

  always_comb
  begin
    logic [7:0] pos;
    logic [7:0] dpos;
    pos = q.idx - 8'h01;
    dpos = q.idx - `HP_BYTE_DATA0;
    d = q;
    d.cmd_start = 1'b0;
    d.nvm_done = 1'b0;
    d.nvm_refused = 1'b0;
    host_we = 1'b0;
    host_waddr = dpos[`HP_BUF_AW-1:0];
    nvm_we = 1'b0;
    if (lk_frame_end)
    begin
      d.frame = FR_NONE;
    end
    if (lk_rx_valid && lk_rx_first)
    begin
      d.idx = 8'h00;
      d.ack_ok = 1'b0;
      d.frame = FR_NONE;
      if (lk_rx_data[`HP_DEV_HI:`HP_DEV_LO] == `HP_DEV_ADDR_HI)
      begin
        if (lk_rx_data[`HP_SEL_BIT])
        begin
          d.frame = lk_rx_data[`HP_RW_BIT] ? FR_STATUS : FR_NONE;
          d.ack_ok = lk_rx_data[`HP_RW_BIT];
        end
        else if (!busy_now)
        begin
          d.frame = lk_rx_data[`HP_RW_BIT] ? FR_RESULT : FR_CMD;
          d.ack_ok = 1'b1;
        end
      end
    end
    else if (lk_rx_valid && q.frame == FR_CMD)
    begin
      d.ack_ok = 1'b1;
      if (q.idx != 8'hff)
      begin
        d.idx = q.idx + 8'h01;
      end
      if (q.idx == `HP_BYTE_OPCODE)
      begin
        d.cmd_code = lk_rx_data;
      end
      else if (q.idx == `HP_BYTE_SIZE)
      begin
        d.cmd_size = lk_rx_data;
        if (lk_rx_data == 8'h00)
        begin
          d.cmd_start = 1'b1;
        end
      end
      else if (dpos < q.cmd_size && dpos < 8'(`HP_BUF_DEPTH))
      begin
        host_we = 1'b1;
        if (dpos + 8'h01 == q.cmd_size)
        begin
          d.cmd_start = 1'b1;
        end
      end
      else
      begin
        d.ack_ok = 1'b0;
      end
    end
    else if (lk_rx_valid)
    begin
      d.ack_ok = 1'b0;
    end
    if (d.cmd_start)
    begin
      // ready and the old result length stay visible until the last declared byte lands; each data byte overwrites the buffer as it lands
      d.res_len = 8'h00;
      d.exec = 1'b1;
      d.frame = FR_NONE;
    end
    if (lk_tx_req)
    begin
      d.tx_data = `HP_IDLE_BYTE;
      if (q.idx != 8'hff)
      begin
        d.idx = q.idx + 8'h01;
      end
      if (q.frame == FR_STATUS && q.idx == 8'h00)
      begin
        d.tx_data = q.stat;
      end
      else if (q.frame == FR_RESULT && q.idx == 8'h00)
      begin
        d.tx_data = q.res_len;
      end
      else if (q.frame == FR_RESULT && q.idx <= q.res_len && pos < 8'(`HP_BUF_DEPTH))
      begin
        d.tx_data = buf_mem[pos[`HP_BUF_AW-1:0]];
      end
    end
    if (eng_done)
    begin
      d.exec = 1'b0;
      d.res_len = eng_result_len;
      if (q.err != `HP_ERR_LOCKOUT)
      begin
        d.err = eng_error;
      end
    end
    if (eng_challenge_ok)
    begin
      d.chal = 1'b1;
    end
    if (q.pen_act)
    begin
      if (q.pen_cnt == 32'(PENALTY_CYCLES - 1))
      begin
        d.pen_act = 1'b0;
        if (d.err == `HP_ERR_PENALTY)
        begin
          d.err = `HP_ERR_OK;
        end
      end
      else
      begin
        d.pen_cnt = q.pen_cnt + 32'h1;
      end
    end
    if (eng_penalty)
    begin
      d.pen_act = 1'b1;
      d.pen_cnt = 32'h0;
      if (q.err != `HP_ERR_LOCKOUT)
      begin
        d.err = `HP_ERR_PENALTY;
      end
    end
    d.eng_rdata = buf_mem[eng_buf_addr];
    if (nvm_req)
    begin
      if (hp_nvm_allowed(q.lock[1:0], nvm_kind, nvm_addr))
      begin
        d.nvm_done = 1'b1;
        nvm_we = (nvm_kind == `HP_NK_PLAIN_WR) || (nvm_kind == `HP_NK_CIPH_WR);
        d.nvm_rdata = (nvm_addr == `HP_LOCK_ADDR) ? q.lock : nvm_mem[nvm_addr];
      end
      else
      begin
        d.nvm_refused = 1'b1;
      end
    end
    if (lock_cmd)
    begin
      d.lock = `HP_LOCK_ALL;
    end
    d.stat = hp_status(d.err, d.chal, hp_busy(d.exec, d.pen_act, d.err), d.res_len);
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '{frame: FR_NONE, lock: `HP_LOCK_SHIPPED, tx_data: `HP_IDLE_BYTE, default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  // buffer and storage hold no reset: contents survive like the real cells
  always_ff @(posedge clk_sys)
  begin
    if (host_we)
    begin
      buf_mem[host_waddr] <= lk_rx_data;
    end
    else if (eng_buf_we)
    begin
      buf_mem[eng_buf_addr] <= eng_buf_wdata;
    end
    if (nvm_we)
    begin
      nvm_mem[nvm_addr] <= nvm_wdata;
    end
  end

  assign cmd_start = q.cmd_start;
  assign cmd_code = q.cmd_code;
  assign cmd_size = q.cmd_size;
  assign eng_buf_rdata = q.eng_rdata;
  assign nvm_rdata = q.nvm_rdata;
  assign nvm_done = q.nvm_done;
  assign nvm_refused = q.nvm_refused;
  assign lock_value = q.lock;
  assign host_port_condition = q.stat;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  property p_len_first;
    lk_tx_req && q.frame == FR_RESULT && q.idx == 8'h00 |=> q.tx_data == $past(q.res_len);
  endproperty
  a_len_first: assert property (p_len_first) else $error("length byte not sent first");

  property p_status_rsvd;
    lk_tx_req && q.frame == FR_STATUS && q.idx == 8'h00
      |=> q.tx_data[`HP_ST_RSVD_HI:`HP_ST_RSVD_LO] == `HP_ST_RSVD && q.tx_data == $past(q.stat);
  endproperty
  a_status_rsvd: assert property (p_status_rsvd) else $error("status byte wrong");

  property p_lockout_busy;
    q.err == `HP_ERR_LOCKOUT |-> q.stat[`HP_ST_BUSY_BIT] && busy_now;
  endproperty
  a_lockout_busy: assert property (p_lockout_busy) else $error("lockout without busy");

  property p_pen_busy;
    eng_penalty && q.err != `HP_ERR_LOCKOUT |=> (q.err == `HP_ERR_PENALTY && q.stat[`HP_ST_BUSY_BIT]) [*8];
  endproperty
  a_pen_busy: assert property (p_pen_busy) else $error("penalty not busy");

  property p_chal_hold;
    $rose(q.chal) |=> q.chal [*8];
  endproperty
  a_chal_hold: assert property (p_chal_hold) else $error("challenge flag dropped");

  property p_status_write_nack;
    lk_rx_valid && lk_rx_first && lk_rx_data[`HP_SEL_BIT] && !lk_rx_data[`HP_RW_BIT] |=> !q.ack_ok;
  endproperty
  a_status_write_nack: assert property (p_status_write_nack) else $error("status write acked");

  property p_busy_nack;
    lk_rx_valid && lk_rx_first && !lk_rx_data[`HP_SEL_BIT] && busy_now |=> !q.ack_ok;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("command acked while busy");

  property p_noresult;
    eng_done && eng_result_len == 8'h00 |=> !q.stat[`HP_ST_RDY_BIT] && q.res_len == 8'h00;
  endproperty
  a_noresult: assert property (p_noresult) else $error("ready set without result");

  property p_lock_final;
    q.lock == `HP_LOCK_ALL |=> q.lock == `HP_LOCK_ALL;
  endproperty
  a_lock_final: assert property (p_lock_final) else $error("lock byte changed");

  property p_conf_no_plain_read;
    nvm_req && nvm_kind == `HP_NK_PLAIN_RD && q.lock[1:0] == `HP_LOCK_CONF |=> q.nvm_refused && !q.nvm_done;
  endproperty
  a_conf_no_plain_read: assert property (p_conf_no_plain_read) else $error("plain read allowed");

  property p_empty_cmd_start;
    lk_rx_valid && q.frame == FR_CMD && q.idx == `HP_BYTE_SIZE && lk_rx_data == 8'h00
      |=> q.cmd_start && q.stat[`HP_ST_BUSY_BIT] && !q.stat[`HP_ST_RDY_BIT];
  endproperty
  a_empty_cmd_start: assert property (p_empty_cmd_start) else $error("command not started");

  c_status_read: cover property (lk_tx_req && q.frame == FR_STATUS);
  c_result_read: cover property (lk_tx_req && q.frame == FR_RESULT && q.idx == 8'h02);
  c_cmd_start: cover property (q.cmd_start);
  c_lock: cover property (lock_cmd);
endmodule : hp_host_port

// >>> hp_host_model.sv
// two-wire bus master standing in for the host processor
`timescale 1ns/10ps
module hp_host_model
(
  input wire logic clk_sys,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  output logic scl,
  output logic sda
);
  logic m_sda;
  initial
  begin
    scl = 1'b1;
    m_sda = 1'b1;
  end
  // wired-and with pull-up, so a released line reads high
  assign sda = m_sda & (sda_oe_n | sda_out);
  // 10 clocks a half period keeps above the 8 clock minimum
  task automatic half;
    repeat (10) @(posedge clk_sys);
    #1;
  endtask : half
  // data moves 3 clocks after scl falls so no false start is seen
  task automatic clk_bit(input logic v, output logic s);
    repeat (3) @(posedge clk_sys);
    #1;
    m_sda = v;
    half();
    scl = 1'b1;
    half();
    s = sda;
    scl = 1'b0;
  endtask : clk_bit
  task automatic start;
    half();
    m_sda = 1'b0;
    half();
    scl = 1'b0;
  endtask : start
  task automatic stop;
    repeat (3) @(posedge clk_sys);
    #1;
    m_sda = 1'b0;
    half();
    scl = 1'b1;
    half();
    m_sda = 1'b1;
    half();
  endtask : stop
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask : wr_byte
  task automatic rd_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(1'b1, b[i]);
    clk_bit(nack, s);
  endtask : rd_byte
endmodule : hp_host_model

// >>> hp_host_port_bench.sv
// self-checking bench for the host port
`timescale 1ns/10ps
module hp_host_port_bench;
  localparam int PEN = 20;
  logic clk_sys, reset_n, scl, sda, sda_out, sda_oe_n, cmd_start, eng_done, eng_penalty, eng_challenge_ok;
  logic eng_buf_we, nvm_req, lock_cmd, nvm_done, nvm_refused;
  logic [7:0] cmd_code, cmd_size, eng_result_len, eng_buf_wdata, eng_buf_rdata, nvm_wdata, nvm_rdata;
  logic [7:0] lock_value, stat;
  logic [2:0] eng_error, nvm_kind;
  logic [5:0] eng_buf_addr;
  logic [8:0] nvm_addr;
  int error_cnt = 0;
  int n_checks = 0;
  int n_starts = 0;
  hp_host_port #(.PENALTY_CYCLES(PEN)) u_hp_host_port (.clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .cmd_start(cmd_start), .cmd_code(cmd_code),
    .cmd_size(cmd_size), .eng_done(eng_done), .eng_result_len(eng_result_len), .eng_error(eng_error),
    .eng_penalty(eng_penalty), .eng_challenge_ok(eng_challenge_ok), .eng_buf_we(eng_buf_we),
    .eng_buf_addr(eng_buf_addr), .eng_buf_wdata(eng_buf_wdata), .eng_buf_rdata(eng_buf_rdata),
    .nvm_req(nvm_req), .nvm_kind(nvm_kind), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .lock_cmd(lock_cmd),
    .nvm_rdata(nvm_rdata), .nvm_done(nvm_done), .nvm_refused(nvm_refused), .lock_value(lock_value),
    .host_port_condition(stat));
  hp_host_model u_hp_host_model (.clk_sys(clk_sys), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    if (cmd_start === 1'b1)
      n_starts++;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h0, got}, {7'h0, exp});
  endtask : chk_bit
  task automatic addr(input logic [7:0] a, input logic exp_ack);
    logic ack;
    u_hp_host_model.start();
    u_hp_host_model.wr_byte(a, ack);
    chk_bit(ack, exp_ack);
  endtask : addr
  task automatic rd_status(input logic [7:0] exp);
    logic [7:0] b;
    addr(8'hc3, 1'b1);
    u_hp_host_model.rd_byte(1'b1, b);
    u_hp_host_model.stop();
    chk_byte(b, exp);
  endtask : rd_status
  task automatic rd_result(input logic [7:0] len, input logic [7:0] d0, input logic [7:0] d1);
    logic [7:0] b;
    addr(8'hc1, 1'b1);
    u_hp_host_model.rd_byte(len == 8'h00, b);
    chk_byte(b, len);
    for (int i = 0; i < len; i++)
    begin
      u_hp_host_model.rd_byte(i == len - 1, b);
      chk_byte(b, (i == 0) ? d0 : d1);
    end
    u_hp_host_model.stop();
  endtask : rd_result
  task automatic send_cmd(input logic [7:0] op, input logic [7:0] n, input logic [7:0] d0, input logic [7:0] d1);
    logic ack;
    logic rdy;
    rdy = stat[0];
    addr(8'hc0, 1'b1);
    u_hp_host_model.wr_byte(op, ack);
    chk_bit(ack, 1'b1);
    // old ready must survive until the declared bytes are in
    chk_bit(stat[0], rdy);
    u_hp_host_model.wr_byte(n, ack);
    chk_bit(ack, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      u_hp_host_model.wr_byte((i == 0) ? d0 : d1, ack);
      chk_bit(ack, 1'b1);
    end
    u_hp_host_model.stop();
    tick(4);
  endtask : send_cmd
  task automatic finish_cmd(input logic [7:0] len, input logic [2:0] err);
    eng_result_len = len;
    eng_error = err;
    eng_done = 1'b1;
    tick(1);
    eng_done = 1'b0;
    tick(3);
  endtask : finish_cmd
  // outcome may show one or a few cycles after the request, so wait bounded
  task automatic nvm(input logic [2:0] k, input logic [8:0] a, input logic ok, input logic [7:0] exp);
    nvm_kind = k;
    nvm_addr = a;
    nvm_req = 1'b1;
    tick(1);
    nvm_req = 1'b0;
    for (int i = 0; i < 3 && nvm_done !== 1'b1 && nvm_refused !== 1'b1; i++)
      tick(1);
    chk_bit(nvm_done, ok);
    chk_bit(nvm_refused, ~ok);
    if (k == 3'h4)
      chk_byte(nvm_rdata, exp);
    tick(2);
  endtask : nvm
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #900000;
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    {reset_n, eng_done, eng_penalty, eng_challenge_ok, eng_buf_we, nvm_req, lock_cmd} = '0;
    {eng_result_len, eng_error, eng_buf_addr, eng_buf_wdata, nvm_kind, nvm_addr, nvm_wdata} = '0;
    repeat (4) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    tick(5);
    rd_status(8'h00);
    addr(8'hc2, 1'b0);
    u_hp_host_model.stop();
    $display("test idle status done");
    send_cmd(8'h10, 8'h02, 8'ha5, 8'h3c);
    chk_byte(8'(n_starts), 8'h01);
    chk_byte(cmd_code, 8'h10);
    chk_byte(cmd_size, 8'h02);
    rd_status(8'h02);
    addr(8'hc1, 1'b0);
    u_hp_host_model.stop();
    eng_buf_addr = 6'h01;
    tick(2);
    chk_byte(eng_buf_rdata, 8'h3c);
    eng_buf_we = 1'b1;
    eng_buf_addr = 6'h00;
    eng_buf_wdata = 8'h5a;
    tick(1);
    eng_buf_addr = 6'h01;
    eng_buf_wdata = 8'hc3;
    tick(1);
    eng_buf_we = 1'b0;
    finish_cmd(8'h02, 3'h0);
    rd_status(8'h01);
    rd_result(8'h02, 8'h5a, 8'hc3);
    rd_result(8'h02, 8'h5a, 8'hc3);
    $display("test result read done");
    send_cmd(8'h14, 8'h00, 8'h00, 8'h00);
    rd_status(8'h02);
    finish_cmd(8'h00, 3'h0);
    rd_status(8'h00);
    rd_result(8'h00, 8'h00, 8'h00);
    for (int e = 2; e <= 4; e += 2)
    begin
      send_cmd(8'h04, 8'h00, 8'h00, 8'h00);
      finish_cmd(8'h00, 3'(e));
      rd_status({3'(e), 5'h00});
    end
    send_cmd(8'h03, 8'h00, 8'h00, 8'h00);
    eng_challenge_ok = 1'b1;
    tick(1);
    eng_challenge_ok = 1'b0;
    finish_cmd(8'h00, 3'h0);
    rd_status(8'h04);
    $display("test error codes done");
    eng_penalty = 1'b1;
    tick(1);
    eng_penalty = 1'b0;
    tick(3);
    chk_byte(stat, 8'h66);
    tick(10);
    chk_byte(stat, 8'h66);
    tick(PEN);
    chk_byte(stat, 8'h04);
    send_cmd(8'h01, 8'h00, 8'h00, 8'h00);
    finish_cmd(8'h00, 3'h1);
    rd_status(8'h26);
    addr(8'hc0, 1'b0);
    u_hp_host_model.stop();
    tick(PEN + 5);
    rd_status(8'h26);
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    tick(5);
    rd_status(8'h00);
    $display("test penalty and lockout done");
    chk_byte(lock_value, 8'h02);
    nvm(3'h4, 9'h02f, 1'b1, 8'h02);
    nvm(3'h1, 9'h02f, 1'b0, 8'h00);
    nvm(3'h0, 9'h100, 1'b0, 8'h00);
    nvm(3'h3, 9'h100, 1'b1, 8'h00);
    nvm(3'h2, 9'h100, 1'b1, 8'h00);
    lock_cmd = 1'b1;
    tick(1);
    lock_cmd = 1'b0;
    tick(2);
    chk_byte(lock_value, 8'hff);
    nvm(3'h4, 9'h02f, 1'b1, 8'hff);
    nvm(3'h1, 9'h02f, 1'b0, 8'h00);
    nvm(3'h0, 9'h1ff, 1'b1, 8'h00);
    nvm(3'h3, 9'h100, 1'b0, 8'h00);
    nvm(3'h2, 9'h100, 1'b0, 8'h00);
    $display("test lock byte done");
    tally_and_finish();
  end
endmodule : hp_host_port_bench
